// *** logic/nvmab_pkg.sv ***
`default_nettype none
package nvmab_pkg;

    // Register offsets on the internal register port.
    localparam logic [7:0] ADDR_READY        = 8'h32;
    localparam logic [7:0] ADDR_LOCATION     = 8'h33;
    localparam logic [7:0] ADDR_WRITE_DATA   = 8'h34;
    localparam logic [7:0] ADDR_ACCESS_CTRL  = 8'h35;
    localparam logic [7:0] ADDR_SINGLE_READ  = 8'h36;
    localparam logic [7:0] ADDR_HOLE1_LO     = 8'h37;
    localparam logic [7:0] ADDR_HOLE1_HI     = 8'h5F;
    localparam logic [7:0] ADDR_NVM_CONTROL  = 8'h60;
    localparam logic [7:0] ADDR_HOLE2_LO     = 8'h61;
    localparam logic [7:0] ADDR_HOLE2_HI     = 8'h8F;
    localparam logic [7:0] ADDR_CONFIG_ONE   = 8'h90;

    // Field positions.
    localparam int BIT_MOTOR_INHIBIT = 15;
    localparam int BIT_MIRROR_USE    = 12;
    localparam int BIT_WRITE_NOT_RD  = 2;
    localparam int BIT_MODE_HI       = 1;
    localparam int BIT_MODE_LO       = 0;
    localparam int BIT_READY         = 0;

    // Reset values.
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [7:0]  RESET_LOCATION = 8'h00;

    // Store geometry and busy time of one store access, in cycles.
    localparam int NVM_DEPTH    = 256;
    localparam int ACCESS_CYCLES = 4;
    localparam logic [2:0] ACCESS_COUNT = 3'(ACCESS_CYCLES);

    // Store access modes.
    typedef enum logic [1:0] {
        NVMAB_MODE_OFF    = 2'b00,
        NVMAB_MODE_SINGLE = 2'b01,
        NVMAB_MODE_MASS   = 2'b10,
        NVMAB_MODE_RSVD   = 2'b11
    } nvmab_mode_type;

    // Layout of the first configuration word.
    typedef struct packed {
        logic [1:0] dither_select;
        logic [1:0] tach_openloop_gate;
        logic [3:0] tach_divide;
        logic       cycle_adjust_select;
        logic [2:0] phase_res_shift;
        logic [3:0] phase_res_mantissa;
    } nvmab_cfg1_type;

    // Settings handed to the motor control logic.
    typedef struct packed {
        logic [1:0]  dither_select;
        logic [1:0]  tach_openloop_gate;
        logic [4:0]  tach_divisor;
        logic        cycle_adjust_select;
        logic [10:0] phase_res_code;
    } nvmab_settings_type;

endpackage
`default_nettype wire

// *** logic/nvmab_bank.sv ***
// How it works
// - Mode 00 off, 01 single, 10 mass.
// - Single read word holds last fetched location.
// - Addresses 0x37 to 0x5F are unimplemented holes.
// - Addresses 0x61 to 0x8F are unimplemented holes.
// - Bit 15 of control stops motor control.
// - Motor inhibit bit never reads back.
// - Bits 15:14 pick clock dithering depth.
// - Bits 13:12 gate the tachometer output.
// - Tachometer divides speed by field plus one.
// - Bit 7 picks full or half cycle adjust.
// - Resistance code is mantissa shifted by count.
// - Location register names the store word of a single access.
// - Direction bit: zero reads, one writes.
// - Mirror enable makes operation use mirror values.
// - Ready flag shows store can take access.
`timescale 1ns/1ns
`default_nettype none
module nvmab_bank (
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    input  wire logic                          clk_en,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [15:0]                   reg_wdata,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    output logic [15:0]                        reg_rdata,
    output logic                               reg_rvalid,
    output logic                               motor_inhibit,
    output nvmab_pkg::nvmab_settings_type      settings
);

    // Flags an address that falls in one of the two unused holes.
    function automatic logic in_hole(input logic [7:0] addr);
        in_hole = ((addr >= nvmab_pkg::ADDR_HOLE1_LO)
                   && (addr <= nvmab_pkg::ADDR_HOLE1_HI))
               || ((addr >= nvmab_pkg::ADDR_HOLE2_LO)
                   && (addr <= nvmab_pkg::ADDR_HOLE2_HI));
    endfunction

    logic [15:0]               store [nvmab_pkg::NVM_DEPTH];
    logic [15:0]               mirror_word;
    logic [15:0]               write_data;
    logic [15:0]               single_read_value;
    logic [7:0]                single_access_location;
    logic                      mirror_use_enable;
    logic                      write_not_read_select;
    nvmab_pkg::nvmab_mode_type nvm_access_mode;
    logic [2:0]                busy_count;
    logic [2:0]                next_busy_count;
    logic [15:0]               next_rdata;

    // Ready is low while the busy countdown of an access runs.
    wire logic nvm_ready_flag = (busy_count == 3'h0);

    // Write strobes, one per writable register offset.
    wire logic wr_location    = reg_write
                                && (reg_addr == nvmab_pkg::ADDR_LOCATION);
    wire logic wr_write_data  = reg_write
                                && (reg_addr == nvmab_pkg::ADDR_WRITE_DATA);
    wire logic wr_ctrl        = reg_write
                                && (reg_addr == nvmab_pkg::ADDR_ACCESS_CTRL);
    wire logic wr_nvm_control = reg_write
                                && (reg_addr == nvmab_pkg::ADDR_NVM_CONTROL);
    wire logic wr_config_one  = reg_write
                                && (reg_addr == nvmab_pkg::ADDR_CONFIG_ONE);

    // Fields carried by a write to the access or motor control register.
    wire nvmab_pkg::nvmab_mode_type new_mode =
        nvmab_pkg::nvmab_mode_type'(
            reg_wdata[nvmab_pkg::BIT_MODE_HI:nvmab_pkg::BIT_MODE_LO]);
    wire logic new_dir        = reg_wdata[nvmab_pkg::BIT_WRITE_NOT_RD];
    wire logic new_mirror_use = reg_wdata[nvmab_pkg::BIT_MIRROR_USE];
    wire logic new_inhibit    = reg_wdata[nvmab_pkg::BIT_MOTOR_INHIBIT];

    // An access starts only on a control write with mode 01 or 10 while
    // the store is ready. Mode 00 and the reserved mode 11 start nothing,
    // and a request made while busy is dropped, not queued, so the host
    // must poll the ready flag before it asks again.
    wire logic launch_single = wr_ctrl && nvm_ready_flag
                               && (new_mode == nvmab_pkg::NVMAB_MODE_SINGLE);
    wire logic launch_mass = wr_ctrl && nvm_ready_flag
                             && (new_mode == nvmab_pkg::NVMAB_MODE_MASS);
    wire logic launch = launch_single || launch_mass;

    // The four kinds of access, told apart by the direction bit.
    wire logic single_write = launch_single && new_dir;
    wire logic single_read  = launch_single && !new_dir;
    wire logic mass_write   = launch_mass && new_dir;
    wire logic mass_read    = launch_mass && !new_dir;

    // The configuration word in force follows the mirror when mirror use
    // is enabled and the store word at the first configuration location
    // otherwise; register reads of that offset see the same choice.
    wire logic [15:0] store_cfg1 = store[nvmab_pkg::ADDR_CONFIG_ONE];
    wire logic [15:0] live_cfg1 = mirror_use_enable ? mirror_word
                                                    : store_cfg1;
    wire nvmab_pkg::nvmab_cfg1_type cfg1 = live_cfg1;

    // Decoded settings for the motor control logic. The resistance code
    // keeps eleven bits, which holds the largest mantissa at the largest
    // shift, so no part of a legal code is lost.
    wire logic [10:0] res_code = 11'({7'h00, cfg1.phase_res_mantissa}
                                     << cfg1.phase_res_shift);
    wire logic [4:0] tach_div = {1'b0, cfg1.tach_divide} + 5'h01;
    wire nvmab_pkg::nvmab_settings_type next_settings = '{
        dither_select:       cfg1.dither_select,
        tach_openloop_gate:  cfg1.tach_openloop_gate,
        tach_divisor:        tach_div,
        cycle_adjust_select: cfg1.cycle_adjust_select,
        phase_res_code:      res_code
    };

    // Busy countdown that holds the ready flag low after each access. A
    // launch reloads it; launches cannot overlap since they need ready.
    always_comb begin
        next_busy_count = busy_count;
        if (launch) begin
            next_busy_count = nvmab_pkg::ACCESS_COUNT;
        end else if (busy_count != 3'h0) begin
            next_busy_count = busy_count - 3'h1;
        end
    end

    // Readback image of the access control register; reserved bits are 0.
    wire logic [15:0] ctrl_readback = {3'h0, mirror_use_enable, 9'h000,
                                       write_not_read_select,
                                       nvm_access_mode};

    // Read multiplexer. Holes and unmapped offsets return zero, and the
    // motor control register hides its write-only inhibit bit.
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_addr == nvmab_pkg::ADDR_READY) begin
            next_rdata = {15'h0000, nvm_ready_flag};
        end else if (reg_addr == nvmab_pkg::ADDR_LOCATION) begin
            next_rdata = {8'h00, single_access_location};
        end else if (reg_addr == nvmab_pkg::ADDR_WRITE_DATA) begin
            next_rdata = write_data;
        end else if (reg_addr == nvmab_pkg::ADDR_ACCESS_CTRL) begin
            next_rdata = ctrl_readback;
        end else if (reg_addr == nvmab_pkg::ADDR_SINGLE_READ) begin
            next_rdata = single_read_value;
        end else if (reg_addr == nvmab_pkg::ADDR_NVM_CONTROL) begin
            next_rdata = 16'h0000;
        end else if (reg_addr == nvmab_pkg::ADDR_CONFIG_ONE) begin
            next_rdata = live_cfg1;
        end else if (in_hole(reg_addr)) begin
            next_rdata = 16'h0000;
        end
    end

    // Host-visible control registers. A control write that finds the store
    // busy still updates its fields; only the access itself is dropped.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            single_access_location <= nvmab_pkg::RESET_LOCATION;
            write_data             <= nvmab_pkg::RESET_WORD;
            mirror_use_enable      <= 1'b0;
            write_not_read_select  <= 1'b0;
            nvm_access_mode        <= nvmab_pkg::NVMAB_MODE_OFF;
            motor_inhibit          <= 1'b0;
            mirror_word            <= nvmab_pkg::RESET_WORD;
            busy_count             <= 3'h0;
        end else if (clk_en) begin
            busy_count <= next_busy_count;
            if (wr_location) begin
                single_access_location <= reg_wdata[7:0];
            end
            if (wr_write_data) begin
                write_data <= reg_wdata;
            end
            if (wr_ctrl) begin
                mirror_use_enable     <= new_mirror_use;
                write_not_read_select <= new_dir;
                nvm_access_mode       <= new_mode;
            end
            if (wr_nvm_control) begin
                motor_inhibit <= new_inhibit;
            end
            // A mass read reloads the mirror; otherwise host writes do.
            if (mass_read) begin
                mirror_word <= store_cfg1;
            end else if (wr_config_one) begin
                mirror_word <= reg_wdata;
            end
        end
    end

    // Store array and the single read word it feeds. The array clears on
    // reset, standing in for cells that a real part would keep; a test
    // that needs old contents must write them after reset.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            single_read_value <= nvmab_pkg::RESET_WORD;
            for (int i = 0; i < nvmab_pkg::NVM_DEPTH; i++) begin
                store[i] <= nvmab_pkg::RESET_WORD;
            end
        end else if (clk_en) begin
            if (single_write) begin
                store[single_access_location] <= write_data;
            end else if (single_read) begin
                single_read_value <= store[single_access_location];
            end else if (mass_write) begin
                store[nvmab_pkg::ADDR_CONFIG_ONE] <= mirror_word;
            end
        end
    end

    // Read answer and registered settings. Settings trail the word in
    // force by one cycle, so all their fields change on one edge.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
            settings   <= '0;
        end else if (clk_en) begin
            reg_rvalid <= reg_read;
            settings   <= next_settings;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule
`default_nettype wire

// *** sim/nvmab_bank_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module nvmab_chk (
    input wire logic                          core_clk,
    input wire logic                          srst,
    input wire logic                          clk_en,
    input wire logic [7:0]                    reg_addr,
    input wire logic [15:0]                   reg_wdata,
    input wire logic                          reg_write,
    input wire logic                          reg_read,
    input wire logic [15:0]                   reg_rdata,
    input wire logic                          reg_rvalid,
    input wire logic                          motor_inhibit,
    input wire nvmab_pkg::nvmab_settings_type settings
);
    logic [15:0] mir;
    logic        men;
    logic        mir_ok;
    logic [1:0]  settle;
    wire         rd = clk_en && reg_read;
    wire         wr = clk_en && reg_write;
    // Tracks the mirror word and how many cycles it has been steady. A
    // mass read reloads the mirror from a store this checker cannot see,
    // so the mirror checks rest until the host writes the mirror again.
    always_ff @(posedge core_clk) begin
        if (srst || !clk_en || (wr && reg_addr inside {8'h90, 8'h35}))
            settle <= 2'h0;
        else if (settle != 2'h3)
            settle <= settle + 2'h1;
        if (srst) begin
            mir    <= 16'h0000;
            men    <= 1'b0;
            mir_ok <= 1'b1;
        end else begin
            if (wr && reg_addr == 8'h90) begin
                mir    <= reg_wdata;
                mir_ok <= 1'b1;
            end else if (wr && reg_addr == 8'h35 && reg_wdata[2:0] == 3'b010)
                mir_ok <= 1'b0;
            if (wr && reg_addr == 8'h35)
                men <= reg_wdata[12];
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    a_rvalid_read: assert property (rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_idle: assert property (clk_en && !reg_read
        |=> !reg_rvalid) else $error("stray read answer");
    a_inhibit_set: assert property (wr && reg_addr == 8'h60
        |=> motor_inhibit == $past(reg_wdata[15]))
        else $error("inhibit not taken");
    a_inhibit_hold: assert property (!(wr && reg_addr == 8'h60)
        |=> $stable(motor_inhibit)) else $error("inhibit moved");
    a_ctrl_reads_zero: assert property (rd && reg_addr == 8'h60
        |=> reg_rdata == 16'h0000) else $error("control readback");
    a_hole_one: assert property (rd && reg_addr inside {[8'h37:8'h5F]}
        |=> reg_rdata == 16'h0000) else $error("first hole data");
    a_hole_two: assert property (rd && reg_addr inside {[8'h61:8'h8F]}
        |=> reg_rdata == 16'h0000) else $error("second hole data");
    a_mirror_code: assert property (men && mir_ok && settle == 2'h3
        |-> settings.phase_res_code == 11'(11'(mir[3:0]) << mir[6:4]))
        else $error("resistance code wrong");
    a_mirror_fields: assert property (
        men && mir_ok && settle == 2'h3 |->
        settings.tach_divisor == 5'(mir[11:8]) + 5'h01
        && {settings.dither_select, settings.tach_openloop_gate}
           == mir[15:12]
        && settings.cycle_adjust_select == mir[7])
        else $error("mirror fields wrong");
    a_divisor_live: assert property (!$past(srst) && !$past(srst, 2)
        |-> settings.tach_divisor != 5'h00) else $error("divisor zero");
    cover property (rd && reg_addr == 8'h36);
    cover property (men && settle == 2'h3);
    cover property (wr && reg_addr == 8'h60 && reg_wdata[15]);
endmodule
`default_nettype wire

// *** sim/nvmab_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module nvmab_host (
    input  wire logic        core_clk,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_write,
    output logic             reg_read,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // Idle bus at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // One write strobe; the next call waits for a fresh edge.
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // One read strobe; the answer is taken once it has settled.
    task automatic rd(input logic [7:0] a, output logic [15:0] q,
                      output logic ok);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        ok = reg_rvalid;
        q = reg_rdata;
    endtask
    // Splits a resistance code into shift and four-bit mantissa.
    function automatic logic [6:0] enc(input logic [10:0] c);
        logic [2:0] s;
        s = 3'h0;
        while ((c >> s) > 11'h00f)
            s = s + 3'h1;
        return {s, 4'(c >> s)};
    endfunction
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                          core_clk;
    logic                          srst;
    logic                          clk_en;
    logic [7:0]                    reg_addr;
    logic [15:0]                   reg_wdata;
    logic [15:0]                   reg_rdata;
    logic                          reg_write;
    logic                          reg_read;
    logic                          reg_rvalid;
    logic                          motor_inhibit;
    nvmab_pkg::nvmab_settings_type settings;
    logic [15:0]                   d;
    logic [15:0]                   cfg;
    logic                          v;
    int                            mismatches = 0;
    int                            cmp_count = 0;
    int                            cycles = 0;
    logic [7:0]                    nvmab_hole [4] = '{8'h37, 8'h5F,
                                                      8'h61, 8'h8F};
    nvmab_bank i_nvmab_bank (.core_clk, .srst, .clk_en, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
        .motor_inhibit, .settings);
    nvmab_host i_nvmab_host (.core_clk, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .reg_rvalid);
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        i_nvmab_host.rd(a, d, v);
        chk("rvalid", 16'(v), 16'h0001);
        chk("rdata", d, e);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Clock and a cycle ceiling that cuts a hang short.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Main sequence of register accesses.
    initial begin
        srst = 1'b1;
        clk_en = 1'b1;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        rchk(8'h36, 16'h0000);
        i_nvmab_host.wr(8'h60, 16'h8000);
        #1 chk("inhibit", 16'(motor_inhibit), 16'h0001);
        rchk(8'h60, 16'h0000);
        i_nvmab_host.wr(8'h60, 16'h0000);
        #1 chk("inhibit", 16'(motor_inhibit), 16'h0000);
        // A write made while the clock enable is low must change nothing.
        @(posedge core_clk);
        clk_en <= 1'b0;
        i_nvmab_host.wr(8'h60, 16'h8000);
        clk_en <= 1'b1;
        #1 chk("frozen", 16'(motor_inhibit), 16'h0000);
        foreach (nvmab_hole[i]) begin
            i_nvmab_host.wr(nvmab_hole[i], 16'hFFFF);
            rchk(nvmab_hole[i], 16'h0000);
        end
        i_nvmab_host.wr(8'h33, 16'h0012);
        i_nvmab_host.wr(8'h34, 16'hA5C3);
        i_nvmab_host.wr(8'h35, 16'h0005);
        rchk(8'h32, 16'h0000);
        repeat (6) @(posedge core_clk);
        rchk(8'h32, 16'h0001);
        i_nvmab_host.wr(8'h34, 16'h0000);
        i_nvmab_host.wr(8'h35, 16'h0001);
        repeat (6) @(posedge core_clk);
        rchk(8'h36, 16'hA5C3);
        i_nvmab_host.wr(8'h36, 16'h1111);
        i_nvmab_host.wr(8'h33, 16'h0013);
        rchk(8'h33, 16'h0013);
        i_nvmab_host.wr(8'h35, 16'h0000);
        repeat (6) @(posedge core_clk);
        rchk(8'h36, 16'hA5C3);
        cfg = {2'b10, 2'b01, 4'hF, 1'b1, i_nvmab_host.enc(11'd300)};
        i_nvmab_host.wr(8'h90, cfg);
        i_nvmab_host.wr(8'h35, 16'h1000);
        rchk(8'h90, cfg);
        chk("divisor", 16'(settings.tach_divisor), 16'd16);
        chk("code", 16'(settings.phase_res_code), 16'd288);
        chk("fields", 16'({settings.dither_select,
            settings.tach_openloop_gate,
            settings.cycle_adjust_select}), 16'h0013);
        i_nvmab_host.wr(8'h35, 16'h1006);
        repeat (6) @(posedge core_clk);
        i_nvmab_host.wr(8'h35, 16'h0000);
        rchk(8'h90, cfg);
        chk("divisor", 16'(settings.tach_divisor), 16'd16);
        // Mass read: the mirror is cleared, then reloaded from the store.
        i_nvmab_host.wr(8'h90, 16'h0000);
        i_nvmab_host.wr(8'h35, 16'h1002);
        repeat (6) @(posedge core_clk);
        rchk(8'h90, cfg);
        chk("divisor", 16'(settings.tach_divisor), 16'h0010);
        give_verdict();
    end
endmodule
bind nvmab_bank nvmab_chk i_nvmab_chk (.core_clk, .srst, .clk_en, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
    .motor_inhibit, .settings);
`default_nettype wire
